// *** dsm_pkg.sv ***
// Constants, types and register map shared by the drive select and motor decode block
package dsm_pkg;

    // ------------------------------------------------------------
    // Host port addresses and register reset values
    // ------------------------------------------------------------
    localparam logic [9:0] DSM_ADDR_DRIVE_CTRL = 10'h3F2;   // Drive control register port
    localparam logic [9:0] DSM_ADDR_TAPE_SEL   = 10'h3F3;   // Tape select register port
    localparam logic [7:0] DSM_DRIVE_CTRL_RST  = 8'h00;     // Drive control after hard reset
    localparam logic [1:0] DSM_TAPE_SEL_RST    = 2'h0;      // Tape select after hard reset
    localparam logic [5:0] DSM_TAPE_UNUSED     = 6'h00;     // Filler for undriven tape bits

    // ------------------------------------------------------------
    // Data pin enables (low means the pin is driven)
    // ------------------------------------------------------------
    localparam logic [7:0] DSM_OE_N_IDLE = 8'hFF;           // Bus released
    localparam logic [7:0] DSM_OE_N_FULL = 8'h00;           // All eight bits driven
    localparam logic [7:0] DSM_OE_N_TAPE = 8'hFC;           // Only bits 1:0 driven

    // ------------------------------------------------------------
    // Drive and motor pin levels
    // ------------------------------------------------------------
    localparam logic [3:0] DSM_PINS_OFF  = 4'hF;            // Every active-low pin released

    // Tape select codes: which tape drive software believes is selected
    typedef enum logic [1:0] {
        DSM_TAPE_NONE = 2'h0,
        DSM_TAPE_DRV1 = 2'h1,
        DSM_TAPE_DRV2 = 2'h2,
        DSM_TAPE_DRV3 = 2'h3
    } dsm_tape_sel_t;

    // Drive control register layout
    typedef struct packed {
        logic [3:0] motor_en;       // Motor enables, drives 3..0
        logic       dma_en;         // DMA and interrupt enable
        logic       ctrl_reset_n;   // Controller software reset, active low
        logic [1:0] drive_sel;      // Binary drive select field
    } dsm_drive_ctrl_t;

    // Drive interface pin group
    typedef struct packed {
        logic [3:0] select_n;       // Drive select outputs, active low
        logic [3:0] motor_n;        // Motor on outputs, active low
    } dsm_drive_pins_t;

    // Host bus pin group, before and after synchronisation
    typedef struct packed {
        logic [9:0] addr;           // Port address
        logic [7:0] data;           // Write data
        logic       rd_n;           // Read strobe, active low
        logic       wr_n;           // Write strobe, active low
    } dsm_host_bus_t;

    // Host cycle tracker, one-hot
    typedef enum logic [2:0] {
        DSM_ST_IDLE    = 3'h1,
        DSM_ST_WR_WAIT = 3'h2,
        DSM_ST_READ    = 3'h4
    } dsm_state_t;

endpackage

// *** dsm_decode.sv ***
// Combinational decode of the drive control register into drive pin levels
`timescale 1ns/1ns

module dsm_decode (
    input  wire dsm_pkg::dsm_drive_ctrl_t ctrl_i,
    input  wire logic                     ext_i,
    input  wire logic                     swap_i,
    output dsm_pkg::dsm_drive_pins_t      pins_o
);
    import dsm_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Exchange codes 0 and 1, leave 2 and 3 alone
    function automatic logic [1:0] swap01(input logic [1:0] f);
        swap01 = f[1] ? f : {1'b0, ~f[0]};
    endfunction

    wire logic [1:0] sel_field = swap_i ? swap01(ctrl_i.drive_sel) : ctrl_i.drive_sel;
    // The motor bit of the drive named in the field, before any swap
    wire logic       sel_motor = ctrl_i.motor_en[ctrl_i.drive_sel];
    wire logic [3:0] one_hot_n = ~(4'h1 << sel_field);
    wire logic [3:0] mtr_direct = swap_i
        ? ~{ctrl_i.motor_en[3:2], ctrl_i.motor_en[0], ctrl_i.motor_en[1]}
        : ~ctrl_i.motor_en;

    // ------------------------------------------------------------
    // Output selection
    // ------------------------------------------------------------
    always_comb begin
        if (ext_i) begin
            // Encoded field for an outside decoder; upper pins parked high
            pins_o.select_n = {2'b11, sel_field};
            pins_o.motor_n  = {3'b111, ~sel_motor};
        end else begin
            // Direct select only while the chosen drive's motor is enabled
            pins_o.select_n = sel_motor ? one_hot_n : DSM_PINS_OFF;
            pins_o.motor_n  = mtr_direct;
        end
    end

endmodule

// *** dsm_top.sv ***
// Host register file, drive select and motor decode, and tape select register
`timescale 1ns/1ns

module dsm_top (
    input  wire logic                 MCLK_I,
    input  wire logic                 RSTN_I,
    input  wire logic [9:0]           ADDR_I,
    input  wire logic [7:0]           DATA_I,
    input  wire logic                 RD_N_I,
    input  wire logic                 WR_N_I,
    input  wire logic                 DECODE_EXT_I,
    input  wire logic                 DRIVE_SWAP_I,
    output logic      [7:0]           DATA_O,
    output logic      [7:0]           DATA_OE_N_O,
    output logic      [3:0]           DRIVE_SELECT_N_O,
    output logic      [3:0]           MOTOR_ON_N_O,
    output logic                      CTRL_RESET_N_O,
    output logic                      DMA_ENABLE_O
);
    import dsm_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    dsm_host_bus_t   bus_raw;        // Pins as they arrive
    dsm_host_bus_t   bus_s1;         // First synchroniser stage
    dsm_host_bus_t   bus_s2;         // Second stage, the only one logic reads
    dsm_state_t      state;          // Host cycle tracker
    dsm_state_t      next_state;
    dsm_drive_ctrl_t drive_ctrl;     // Drive control register
    dsm_drive_ctrl_t next_drive_ctrl;
    dsm_tape_sel_t   tape_sel;       // Tape select register
    dsm_tape_sel_t   next_tape_sel;
    dsm_drive_pins_t next_pins;      // Decoded pin levels
    logic [7:0]      next_data;
    logic [7:0]      next_oe_n;

    assign bus_raw = '{addr: ADDR_I, data: DATA_I, rd_n: RD_N_I, wr_n: WR_N_I};

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    wire logic hit_ctrl  = (bus_s2.addr == DSM_ADDR_DRIVE_CTRL);
    wire logic hit_tape  = (bus_s2.addr == DSM_ADDR_TAPE_SEL);
    wire logic is_idle   = (state == DSM_ST_IDLE);
    // A write is taken once, on the first synchronised cycle of the strobe
    wire logic wr_ctrl   = is_idle && !bus_s2.wr_n && hit_ctrl;
    wire logic wr_tape   = is_idle && !bus_s2.wr_n && hit_tape;
    wire logic rd_start  = is_idle && bus_s2.wr_n && !bus_s2.rd_n && (hit_ctrl || hit_tape);

    // ------------------------------------------------------------
    // Host pin synchroniser
    // ------------------------------------------------------------
    // Address and data are carried along with the strobes so that a
    // strobe is never seen before the bytes that travel with it
    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            bus_s1 <= '{addr: '0, data: '0, rd_n: 1'b1, wr_n: 1'b1};
            bus_s2 <= '{addr: '0, data: '0, rd_n: 1'b1, wr_n: 1'b1};
        end else begin
            bus_s1 <= bus_raw;
            bus_s2 <= bus_s1;
        end
    end

    // ------------------------------------------------------------
    // Host cycle tracker
    // ------------------------------------------------------------
    always_comb begin
        case (state)
            DSM_ST_IDLE: begin
                if (!bus_s2.wr_n) begin
                    next_state = DSM_ST_WR_WAIT;
                end else if (rd_start) begin
                    next_state = DSM_ST_READ;
                end else begin
                    next_state = DSM_ST_IDLE;
                end
            end
            // Hold until the strobe goes away, so one write commits once
            DSM_ST_WR_WAIT: begin
                next_state = bus_s2.wr_n ? DSM_ST_IDLE : DSM_ST_WR_WAIT;
            end
            DSM_ST_READ: begin
                next_state = bus_s2.rd_n ? DSM_ST_IDLE : DSM_ST_READ;
            end
            default: begin
                next_state = DSM_ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    // Neither register listens to the software reset bit: only a hard
    // reset returns them to their initial values
    assign next_drive_ctrl = wr_ctrl ? dsm_drive_ctrl_t'(bus_s2.data) : drive_ctrl;
    assign next_tape_sel   = wr_tape ? dsm_tape_sel_t'(bus_s2.data[1:0]) : tape_sel;

    // ------------------------------------------------------------
    // Read data and pin enables
    // ------------------------------------------------------------
    // Data is held for the whole read; tape reads leave bits 7:2 floating
    assign next_data = (next_state != DSM_ST_READ) ? DATA_O
                     : rd_start ? (hit_tape ? {DSM_TAPE_UNUSED, tape_sel} : drive_ctrl)
                     : DATA_O;
    assign next_oe_n = (next_state != DSM_ST_READ) ? DSM_OE_N_IDLE
                     : rd_start ? (hit_tape ? DSM_OE_N_TAPE : DSM_OE_N_FULL)
                     : DATA_OE_N_O;

    // ------------------------------------------------------------
    // Drive decode
    // ------------------------------------------------------------
    dsm_decode u_decode (
        .ctrl_i (drive_ctrl),
        .ext_i  (DECODE_EXT_I),
        .swap_i (DRIVE_SWAP_I),
        .pins_o (next_pins)
    );

    // ------------------------------------------------------------
    // State and registers
    // ------------------------------------------------------------
    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            state      <= DSM_ST_IDLE;
            drive_ctrl <= dsm_drive_ctrl_t'(DSM_DRIVE_CTRL_RST);
            tape_sel   <= dsm_tape_sel_t'(DSM_TAPE_SEL_RST);
        end else begin
            state      <= next_state;
            drive_ctrl <= next_drive_ctrl;
            tape_sel   <= next_tape_sel;
        end
    end

    // ------------------------------------------------------------
    // Output flip-flops
    // ------------------------------------------------------------
    // Pins lag the register by one cycle; costs a cycle, buys glitch-free pins
    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            DATA_O           <= DSM_DRIVE_CTRL_RST;
            DATA_OE_N_O      <= DSM_OE_N_IDLE;
            DRIVE_SELECT_N_O <= DSM_PINS_OFF;
            MOTOR_ON_N_O     <= DSM_PINS_OFF;
            CTRL_RESET_N_O   <= 1'b0;
            DMA_ENABLE_O     <= 1'b0;
        end else begin
            DATA_O           <= next_data;
            DATA_OE_N_O      <= next_oe_n;
            DRIVE_SELECT_N_O <= next_pins.select_n;
            MOTOR_ON_N_O     <= next_pins.motor_n;
            CTRL_RESET_N_O   <= drive_ctrl.ctrl_reset_n;
            DMA_ENABLE_O     <= drive_ctrl.dma_en;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!RSTN_I);

    property p_tape_only_by_write;
        !wr_tape |=> $stable(tape_sel);
    endproperty
    a_tape_only_by_write: assert property (p_tape_only_by_write)
        else $error("tape select changed without a write");

    property p_tape_soft_reset;
        (!drive_ctrl.ctrl_reset_n && !wr_tape) ##1 (!wr_tape) |=> $stable(tape_sel);
    endproperty
    a_tape_soft_reset: assert property (p_tape_soft_reset)
        else $error("tape select disturbed during software reset");

    property p_tape_read_enables;
        (rd_start && hit_tape) |=> (DATA_OE_N_O == DSM_OE_N_TAPE) throughout (state == DSM_ST_READ);
    endproperty
    a_tape_read_enables: assert property (p_tape_read_enables)
        else $error("tape read drove upper data bits");

    property p_tape_store;
        wr_tape |=> (tape_sel == $past(bus_s2.data[1:0]));
    endproperty
    a_tape_store: assert property (p_tape_store)
        else $error("tape select code not stored");

    property p_direct_idle;
        (!DECODE_EXT_I && drive_ctrl.motor_en == 4'h0) |=> (DRIVE_SELECT_N_O == DSM_PINS_OFF);
    endproperty
    a_direct_idle: assert property (p_direct_idle)
        else $error("select asserted with all motors off");

    property p_direct_motor;
        (!DECODE_EXT_I && !DRIVE_SWAP_I) |=> (MOTOR_ON_N_O == ~$past(drive_ctrl.motor_en));
    endproperty
    a_direct_motor: assert property (p_direct_motor)
        else $error("direct motor pins wrong");

    property p_direct_swap;
        (!DECODE_EXT_I && DRIVE_SWAP_I && drive_ctrl.drive_sel == 2'h0
            && drive_ctrl.motor_en[0])
        |=> (DRIVE_SELECT_N_O == 4'hD) && (MOTOR_ON_N_O[0] == ~$past(drive_ctrl.motor_en[1]));
    endproperty
    a_direct_swap: assert property (p_direct_swap)
        else $error("swapped direct decode wrong");

    property p_ext_normal;
        (DECODE_EXT_I && !DRIVE_SWAP_I)
        |=> (DRIVE_SELECT_N_O[1:0] == $past(drive_ctrl.drive_sel)) && MOTOR_ON_N_O[1]
            && (MOTOR_ON_N_O[0] == ~$past(drive_ctrl.motor_en[drive_ctrl.drive_sel]));
    endproperty
    a_ext_normal: assert property (p_ext_normal)
        else $error("encoded decode wrong");

    property p_ext_swap;
        (DECODE_EXT_I && DRIVE_SWAP_I && drive_ctrl.drive_sel == 2'h0)
        |=> (DRIVE_SELECT_N_O[1:0] == 2'h1);
    endproperty
    a_ext_swap: assert property (p_ext_swap)
        else $error("encoded swap wrong");

    property p_write_to_pins;
        (wr_ctrl && bus_s2.data == 8'h1C && !DECODE_EXT_I && !DRIVE_SWAP_I)
        ##1 (!DECODE_EXT_I && !DRIVE_SWAP_I)
        |=> (DRIVE_SELECT_N_O == 4'hE) && (MOTOR_ON_N_O == 4'hE);
    endproperty
    a_write_to_pins: assert property (p_write_to_pins)
        else $error("drive 0 activation not seen two cycles after write");

    property p_tape_readback;
        (rd_start && hit_tape) |=> (DATA_O[1:0] == $past(tape_sel));
    endproperty
    a_tape_readback: assert property (p_tape_readback)
        else $error("tape read returned wrong bits");

    c_ctrl_write:  cover property (wr_ctrl ##[1:8] (DRIVE_SELECT_N_O != 4'hF));
    c_tape_read:   cover property (wr_tape ##[1:20] (rd_start && hit_tape));
    c_ext_swapped: cover property (DECODE_EXT_I && DRIVE_SWAP_I && drive_ctrl.motor_en[1]);

endmodule

// *** dsm_drive_model.sv ***
// Behavioural model of the floppy drives, or of an external two-to-four decoder
`timescale 1ns/1ns

module dsm_drive_model (
    input  wire logic [3:0] select_n_i,
    input  wire logic [3:0] motor_n_i,
    input  wire logic       ext_i,
    output logic      [3:0] selected_o,
    output logic      [3:0] spinning_o
);
    import dsm_pkg::*;

    // ------------------------------------------------------------
    // Drive side view
    // ------------------------------------------------------------
    // A real decoder always has one output low, so it never idles unselected
    always_comb begin
        if (ext_i) begin
            // External decoder turns the code into one select
            selected_o = 4'h1 << select_n_i[1:0];
            spinning_o = motor_n_i[0] ? 4'h0 : selected_o;
        end else begin
            // Direct pins: each drive sees its own select and motor line
            selected_o = ~select_n_i;
            spinning_o = ~motor_n_i;
        end
    end
endmodule

// *** tb_drive_select_motor_decode.sv ***
// Self-checking bench for the drive select and motor decode block
`timescale 1ns/1ns

module tb_drive_select_motor_decode;
    import dsm_pkg::*;

    // ------------------------------------------------------------
    // Stimulus, observation and scoreboard state
    // ------------------------------------------------------------
    logic        mclk  = 1'b0;
    logic        rstn  = 1'b0;
    logic [9:0]  addr  = 10'h000;
    logic [7:0]  wdata = 8'h00;
    logic        rd_n  = 1'b1;
    logic        wr_n  = 1'b1;
    logic        ext   = 1'b0;
    logic        swap  = 1'b0;
    logic        chk   = 1'b0;   // Asks the monitor to compare at the next edge
    logic [7:0]  rdata, oe_n;
    logic [3:0]  sel_n, mot_n, drv_oh, spin;
    logic        crst_n, dma;
    logic [51:0] exp_q[$];       // Notes of {mask, value}
    logic [51:0] e;
    logic [7:0]  drive_control_register   = 8'h00;  // Expected drive control contents
    logic [1:0]  tape  = 2'h0;   // Expected tape select bits
    logic [7:0]  act[6] = '{8'h1C, 8'h2D, 8'h4E, 8'h8F, 8'h03, 8'hF0};
    int          errors = 0;
    int          checks = 0;
    int          cyc    = 0;
    wire  [25:0] obs = {oe_n, rdata, sel_n, mot_n, crst_n, dma};

    initial begin
        forever #5 mclk = ~mclk;
    end

    dsm_top dut_u (.MCLK_I(mclk), .RSTN_I(rstn), .ADDR_I(addr), .DATA_I(wdata),
        .RD_N_I(rd_n), .WR_N_I(wr_n), .DECODE_EXT_I(ext), .DRIVE_SWAP_I(swap),
        .DATA_O(rdata), .DATA_OE_N_O(oe_n), .DRIVE_SELECT_N_O(sel_n),
        .MOTOR_ON_N_O(mot_n), .CTRL_RESET_N_O(crst_n), .DMA_ENABLE_O(dma));

    dsm_drive_model drv_u (.select_n_i(sel_n), .motor_n_i(mot_n), .ext_i(ext),
        .selected_o(drv_oh), .spinning_o(spin));

    // ------------------------------------------------------------
    // Expected pin levels, worked out independently of the design
    // ------------------------------------------------------------
    function automatic logic [7:0] pins(input logic [7:0] d, input logic x, input logic s);
        logic [1:0] f;
        logic [1:0] o;
        logic [3:0] sl;
        logic [3:0] mt;
        f = d[1:0];
        o = (s && !f[1]) ? {1'b0, ~f[0]} : f;   // Swap exchanges codes 0 and 1 only
        if (x) begin
            sl = {2'b11, o};
            mt = {3'b111, ~d[4 + f]};           // Gate uses the unswapped field
        end else begin
            sl = 4'hF;
            mt = ~d[7:4];
            if (s) mt[1:0] = {mt[0], mt[1]};
            if (d[4 + f]) sl[o] = 1'b0;         // No select without its motor bit
        end
        return {sl, mt};
    endfunction

    // ------------------------------------------------------------
    // Host bus tasks; strobes held well past the synchroniser delay
    // ------------------------------------------------------------
    task automatic expect_now(input logic [25:0] m, input logic [25:0] v);
        exp_q.push_back({m, v});
        chk <= 1'b1;
        @(posedge mclk);
        chk <= 1'b0;
    endtask

    task automatic cyc_bus(input logic wr, input logic [9:0] a, input logic [7:0] d);
        addr  <= a;
        wdata <= d;
        if (wr) wr_n <= 1'b0;
        else rd_n <= 1'b0;
        repeat (5) @(posedge mclk);
    endtask

    task automatic bus_end;
        wr_n <= 1'b1;
        rd_n <= 1'b1;
        repeat (5) @(posedge mclk);
    endtask

    task automatic wr_chk(input logic [9:0] a, input logic [7:0] d);
        cyc_bus(1'b1, a, d);
        bus_end;
        if (a == DSM_ADDR_DRIVE_CTRL) drive_control_register = d;
        if (a == DSM_ADDR_TAPE_SEL) tape = d[1:0];
        expect_now({8'hFF, 8'h00, 10'h3FF},
            {DSM_OE_N_IDLE, 8'h00, pins(drive_control_register, ext, swap), drive_control_register[2], drive_control_register[3]});
    endtask

    task automatic rd_chk(input logic [9:0] a);
        logic [15:0] v;
        logic [7:0]  m;
        // Tape reads leave bits 7:2 floating, so only bits 1:0 are compared
        v = (a == DSM_ADDR_TAPE_SEL) ? {DSM_OE_N_TAPE, DSM_TAPE_UNUSED, tape}
          : (a == DSM_ADDR_DRIVE_CTRL) ? {DSM_OE_N_FULL, drive_control_register} : {DSM_OE_N_IDLE, 8'h00};
        m = (a == DSM_ADDR_TAPE_SEL) ? 8'h03 : (a == DSM_ADDR_DRIVE_CTRL) ? 8'hFF : 8'h00;
        cyc_bus(1'b0, a, 8'h00);
        expect_now({8'hFF, m, 10'h3FF}, {v, pins(drive_control_register, ext, swap), drive_control_register[2], drive_control_register[3]});
        bus_end;
    endtask

    // ------------------------------------------------------------
    // Monitor: takes the oldest note whenever a result is presented
    // ------------------------------------------------------------
    always @(posedge mclk) begin
        if (chk) begin
            e = exp_q.pop_front();
            checks = checks + 3;
            if ((obs & e[51:26]) !== e[25:0]) begin
                errors = errors + 1;
                $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e[25:0], obs & e[51:26]);
            end
            if ($countones(drv_oh) > 1) begin
                errors = errors + 1;
                $display("CHECK FAILED t=%0t exp=%h got=%h", $time, 4'h1, drv_oh);
            end
            // Direct pins: a selected drive must also see its motor turned on
            if (!ext && ((drv_oh & ~spin) !== 4'h0)) begin
                errors = errors + 1;
                $display("CHECK FAILED t=%0t exp=%h got=%h", $time, drv_oh, drv_oh & spin);
            end
        end
    end

    // ------------------------------------------------------------
    // Timeout and closing report
    // ------------------------------------------------------------
    task automatic tally_and_finish;
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    always @(posedge mclk) begin
        cyc = cyc + 1;
        if (cyc == 8000) begin
            errors = errors + 1;
            tally_and_finish;
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(84981));
        repeat (5) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        expect_now(26'h3FFFFFF, {DSM_OE_N_IDLE, 8'h00, DSM_PINS_OFF, DSM_PINS_OFF, 2'b00});
        $display("test reset done");
        // Every decode arrangement, activation values and random contents
        for (int md = 0; md < 4; md++) begin
            ext  <= md[1];
            swap <= md[0];
            repeat (2) @(posedge mclk);
            foreach (act[i]) wr_chk(DSM_ADDR_DRIVE_CTRL, act[i]);
            repeat (6) wr_chk(DSM_ADDR_DRIVE_CTRL, 8'($urandom));
            rd_chk(DSM_ADDR_DRIVE_CTRL);
            $display("test decode mode %0d done", md);
        end
        // Tape codes: written, read back, and no effect on the pins
        for (int t = 0; t < 4; t++) begin
            wr_chk(DSM_ADDR_TAPE_SEL, {6'($urandom), 2'(t)});
            rd_chk(DSM_ADDR_TAPE_SEL);
        end
        $display("test tape select done");
        // Software reset pulse through the control bit keeps the tape bits
        wr_chk(DSM_ADDR_DRIVE_CTRL, 8'h18);
        wr_chk(DSM_ADDR_DRIVE_CTRL, 8'h1C);
        rd_chk(DSM_ADDR_TAPE_SEL);
        $display("test soft reset done");
        // Unmapped ports change nothing and drive nothing
        wr_chk(10'h3F1, 8'hFF);
        rd_chk(10'h3F5);
        $display("test unmapped done");
        tally_and_finish;
    end
endmodule
